// File: verilog/bert_params.svh
// Register map, field positions and reset values of the tester block.
// Assumes an 8-bit register port addressed by the byte offsets below.
//
// Notes on behaviour
// - Latched bit count is 32 bits; E6h holds bits 31-24, E5h bits 23-16.
// - Latched error count is 24 bits at E7h, E8h, E9h, low byte first.
// - Receive unframed select 1 passes F-bit data to the checker; 0 withholds.
// - Rising transmit byte-align toggle aligns the generated pattern to bytes.
// - Transmit unframed select 1 sources pattern into F-bit; 0 leaves it alone.
// - Direction 0 sends toward line transmitter and checks the line receiver.
// - Direction 1 sends on system serial out, checks system serial in.
// - Tester runs only while the enable bit is 1.
// - Rising write-quota bit transfers the quota to insertion logic two cycles later.
// - Constant mode with nonzero rate ignores quota and inserts errors forever.
// - Counted mode inserts only as many errors as the quota gives.
// - Rate code 0 inserts nothing; codes 1 to 15 give one in 16 to 262144.
// - Quota is 10 bits: low byte at ECh, bits 9-8 low in EDh.
// - Remaining errors readable anytime: low byte EEh, bits 9-8 at EFh.
// - Rising load-counters bit latches running counts and clears them.
`ifndef BERT_PARAMS_SVH
`define BERT_PARAMS_SVH
`define ADDR_COUNTER_CTRL 8'hE0
`define ADDR_BIT_CNT0 8'hE3
`define ADDR_BIT_CNT1 8'hE4
`define ADDR_BIT_CNT2 8'hE5
`define ADDR_BIT_CNT3 8'hE6
`define ADDR_ERR_CNT0 8'hE7
`define ADDR_ERR_CNT1 8'hE8
`define ADDR_ERR_CNT2 8'hE9
`define ADDR_IF_CTRL 8'hEA
`define ADDR_RATE_CTRL 8'hEB
`define ADDR_QUOTA_LO 8'hEC
`define ADDR_QUOTA_HI 8'hED
`define ADDR_LEFT_LO 8'hEE
`define ADDR_LEFT_HI 8'hEF
`define BIT_LOAD_COUNTERS 1
`define BIT_RX_UNFRAMED 6
`define BIT_TX_ALIGN 4
`define BIT_TX_UNFRAMED 3
`define BIT_DIRECTION 1
`define BIT_ENABLE 0
`define BIT_WRITE_QUOTA 7
`define BIT_CONSTANT 4
`define MASK_COUNTER_CTRL 8'h02
`define MASK_IF_CTRL 8'h5B
`define MASK_RATE_CTRL 8'h9F
`define MASK_QUOTA_HI 8'h03
`define RESET_BYTE 8'h00
`define RATE_SHIFT_BASE 5'h03
`endif

// File: verilog/bert_pkg.sv
// Types shared by the tester block and its bench.
// Assumes the constants header is included where offsets are needed.
package bert_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef enum logic {
		DIR_NETWORK = 1'b0,
		DIR_SYSTEM = 1'b1
	} tester_dir_e;
endpackage

// File: verilog/bert_counters_error_insertion.sv
// Bit error rate tester support: counters, stream routing, error insertion.
// Assumes one clock, a one-cycle bit enable from the framer, an external
// pattern generator and checker, and an 8-bit register port.
//
// Implementation choice: strobed register access.
`include "bert_params.svh"

module bert_counters_error_insertion #(
	parameter int BIT_CNT_W = 32,
	parameter int ERR_CNT_W = 24,
	parameter int QUOTA_W = 10
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic bit_en,
	input wire logic tx_fbit,
	input wire logic rx_fbit,
	input wire logic tx_byte_start,
	input wire logic framer_tx_bit,
	input wire logic framer_rx_bit,
	input wire logic line_rx_bit,
	input wire logic tx_system_serial_in,
	output logic line_tx_bit,
	output logic rx_system_serial_out,
	input wire logic gen_bit,
	output logic gen_advance,
	output logic gen_align,
	output logic chk_bit,
	output logic chk_valid,
	input wire logic chk_err
);

	// The byte-wide register map fixes these widths.
	if (BIT_CNT_W != 32 || ERR_CNT_W != 24 ||
		QUOTA_W != 10) begin : g_bad_widths
		$error("Counter widths must match the byte register map.");
	end

	// Wide enough to count the longest insertion period of 2^18 bits.
	localparam int RATE_CNT_W = 18;

	// Picks byte n of a wide value; used by the bit and error count readbacks.
	function automatic bert_pkg::reg_byte_t pick_byte(
		input logic [31:0] value,
		input logic [1:0] idx
	);
		pick_byte = value[idx*8 +: 8];
	endfunction

	// Rising-edge test shared by the three toggle bits of the host.
	function automatic logic rise_of(
		input logic now,
		input logic was
	);
		rise_of = now & ~was;
	endfunction

	// Software-visible control registers.
	bert_pkg::reg_byte_t counter_ctrl_r;
	bert_pkg::reg_byte_t if_ctrl_r;
	bert_pkg::reg_byte_t rate_ctrl_r;
	bert_pkg::reg_byte_t quota_lo_r;
	bert_pkg::reg_byte_t quota_hi_r;

	// Edge detect history for the toggle bits.
	logic load_prev_r;
	logic align_prev_r;
	logic quota_prev_r;
	logic quota_xfer_r;
	logic align_pend_r;

	// Running and latched counters.
	logic [BIT_CNT_W-1:0] bit_run_r;
	logic [ERR_CNT_W-1:0] err_run_r;
	logic [BIT_CNT_W-1:0] bit_latch_r;
	logic [ERR_CNT_W-1:0] err_latch_r;

	// Error insertion state.
	logic [QUOTA_W-1:0] left_r;
	logic [RATE_CNT_W-1:0] rate_cnt_r;

	logic enable;
	logic rx_unframed;
	logic tx_unframed;
	logic load_counters;
	logic tx_align;
	logic write_quota;
	logic constant_mode;
	logic [3:0] rate_sel;
	bert_pkg::tester_dir_e direction;
	logic load_rise;
	logic align_rise;
	logic quota_rise;
	logic tx_slot;
	logic rx_slot;
	logic rate_tick;
	logic insert_allowed;
	logic insert_err;
	logic tx_data;
	logic rx_sample;
	logic [RATE_CNT_W-1:0] rate_last;
	logic [4:0] rate_shift;

	// Field decode of the control registers.
	// Masked writes keep unused bits at zero, so these decodes never see them.
	assign enable = if_ctrl_r[`BIT_ENABLE];
	assign rx_unframed = if_ctrl_r[`BIT_RX_UNFRAMED];
	assign tx_unframed = if_ctrl_r[`BIT_TX_UNFRAMED];
	assign tx_align = if_ctrl_r[`BIT_TX_ALIGN];
	assign direction = bert_pkg::tester_dir_e'(if_ctrl_r[`BIT_DIRECTION]);
	assign load_counters = counter_ctrl_r[`BIT_LOAD_COUNTERS];
	assign write_quota = rate_ctrl_r[`BIT_WRITE_QUOTA];
	assign constant_mode = rate_ctrl_r[`BIT_CONSTANT];
	assign rate_sel = rate_ctrl_r[3:0];

	// Register writes; unused bits are masked so they read back as zero.
	// Read-only and unmapped offsets fall to the default and change nothing.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			counter_ctrl_r <= `RESET_BYTE;
			if_ctrl_r <= `RESET_BYTE;
			rate_ctrl_r <= `RESET_BYTE;
			quota_lo_r <= `RESET_BYTE;
			quota_hi_r <= `RESET_BYTE;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`ADDR_COUNTER_CTRL: begin
					counter_ctrl_r <= reg_wdata & `MASK_COUNTER_CTRL;
				end
				`ADDR_IF_CTRL: begin
					if_ctrl_r <= reg_wdata & `MASK_IF_CTRL;
				end
				`ADDR_RATE_CTRL: begin
					rate_ctrl_r <= reg_wdata & `MASK_RATE_CTRL;
				end
				`ADDR_QUOTA_LO: begin
					quota_lo_r <= reg_wdata;
				end
				`ADDR_QUOTA_HI: begin
					quota_hi_r <= reg_wdata & `MASK_QUOTA_HI;
				end
				default: begin
				end
			endcase
		end
	end

	// Byte slices of the latched counts, one per readable register.
	bert_pkg::reg_byte_t bit_bytes [4];
	bert_pkg::reg_byte_t err_bytes [3];

	for (genvar i = 0; i < 4; i++) begin : g_bit_bytes
		assign bit_bytes[i] = pick_byte(bit_latch_r, 2'(i));
	end

	for (genvar i = 0; i < 3; i++) begin : g_err_bytes
		assign err_bytes[i] = pick_byte(32'(err_latch_r), 2'(i));
	end

	// Read port: data stand in the cycle after the strobe, zero elsewhere.
	// Unmapped offsets answer zero so software never sees stale data.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			reg_rdata <= `RESET_BYTE;
		end else if (!reg_rd) begin
			reg_rdata <= `RESET_BYTE;
		end else begin
			unique case (reg_addr)
				`ADDR_COUNTER_CTRL: begin
					reg_rdata <= counter_ctrl_r;
				end
				`ADDR_BIT_CNT0: begin
					reg_rdata <= bit_bytes[0];
				end
				`ADDR_BIT_CNT1: begin
					reg_rdata <= bit_bytes[1];
				end
				`ADDR_BIT_CNT2: begin
					reg_rdata <= bit_bytes[2];
				end
				`ADDR_BIT_CNT3: begin
					reg_rdata <= bit_bytes[3];
				end
				`ADDR_ERR_CNT0: begin
					reg_rdata <= err_bytes[0];
				end
				`ADDR_ERR_CNT1: begin
					reg_rdata <= err_bytes[1];
				end
				`ADDR_ERR_CNT2: begin
					reg_rdata <= err_bytes[2];
				end
				`ADDR_IF_CTRL: begin
					reg_rdata <= if_ctrl_r;
				end
				`ADDR_RATE_CTRL: begin
					reg_rdata <= rate_ctrl_r;
				end
				`ADDR_QUOTA_LO: begin
					reg_rdata <= quota_lo_r;
				end
				`ADDR_QUOTA_HI: begin
					reg_rdata <= quota_hi_r;
				end
				`ADDR_LEFT_LO: begin
					reg_rdata <= left_r[7:0];
				end
				`ADDR_LEFT_HI: begin
					reg_rdata <= {6'h00, left_r[9:8]};
				end
				default: begin
					reg_rdata <= `RESET_BYTE;
				end
			endcase
		end
	end

	// Edge history; a bit held high gives no further edge.
	// History resets to the bits' reset level, so no false edge follows.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			load_prev_r <= 1'b0;
			align_prev_r <= 1'b0;
			quota_prev_r <= 1'b0;
		end else begin
			load_prev_r <= load_counters;
			align_prev_r <= tx_align;
			quota_prev_r <= write_quota;
		end
	end

	// Rising edges of the host's toggle bits.
	assign load_rise = rise_of(load_counters, load_prev_r);
	assign align_rise = rise_of(tx_align, align_prev_r);
	assign quota_rise = rise_of(write_quota, quota_prev_r);

	// The quota edge is seen the cycle after the write and applied one
	// cycle later, so the transfer lands on the following clock.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			quota_xfer_r <= 1'b0;
		end else begin
			quota_xfer_r <= quota_rise;
		end
	end

	// Byte alignment waits for the formatter's byte boundary, so the
	// generator restarts exactly on a byte and not mid-octet.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			align_pend_r <= 1'b0;
			gen_align <= 1'b0;
		end else begin
			gen_align <= 1'b0;
			if (align_pend_r && bit_en && tx_byte_start) begin
				align_pend_r <= 1'b0;
				gen_align <= 1'b1;
			end
			if (align_rise) begin
				align_pend_r <= 1'b1;
			end
		end
	end

	// Bit slots the tester owns in each direction.
	assign tx_slot = enable & bit_en & (~tx_fbit | tx_unframed);
	assign rx_slot = enable & bit_en & (~rx_fbit | rx_unframed);
	assign gen_advance = tx_slot;

	// Rate code n gives a period of 2 to the power n+3 bits.
	assign rate_shift = 5'(rate_sel) + `RATE_SHIFT_BASE;
	assign rate_last = RATE_CNT_W'((32'h1 << rate_shift) - 32'h1);
	assign rate_tick = tx_slot && (rate_sel != 4'h0) &&
		(rate_cnt_r >= rate_last);

	// Constant mode ignores the quota; counted mode stops at zero.
	assign insert_allowed = constant_mode | (left_r != '0);
	assign insert_err = rate_tick & insert_allowed;

	// Rate divider counts tester-owned transmit bits only.
	// Clearing it while idle puts the first error a full period in.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rate_cnt_r <= '0;
		end else if (!enable || rate_sel == 4'h0) begin
			rate_cnt_r <= '0;
		end else if (tx_slot) begin
			if (rate_tick) begin
				rate_cnt_r <= '0;
			end else begin
				rate_cnt_r <= rate_cnt_r + 1'b1;
			end
		end
	end

	// Remaining errors; a fresh transfer wins over a same-cycle decrement.
	// Constant mode leaves the count alone so software can still read it.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			left_r <= '0;
		end else if (quota_xfer_r) begin
			left_r <= {quota_hi_r[1:0], quota_lo_r};
		end else if (insert_err && !constant_mode) begin
			left_r <= left_r - 1'b1;
		end
	end

	// Transmitted pattern bit, flipped where an error is inserted.
	// insert_err already implies a tester slot, so framer bits stay clean.
	assign tx_data = gen_bit ^ insert_err;

	// Outgoing streams; the tester only replaces bits in its own slots.
	// Registered so the pins move only at bit times, never between them.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			line_tx_bit <= 1'b0;
			rx_system_serial_out <= 1'b0;
		end else if (bit_en) begin
			if (tx_slot && direction == bert_pkg::DIR_NETWORK) begin
				line_tx_bit <= tx_data;
			end else begin
				line_tx_bit <= framer_tx_bit;
			end
			if (tx_slot && direction == bert_pkg::DIR_SYSTEM) begin
				rx_system_serial_out <= tx_data;
			end else begin
				rx_system_serial_out <= framer_rx_bit;
			end
		end
	end

	// Checker feed chosen by direction.
	// A loopback outside the block returns the network pattern here.
	assign rx_sample = (direction == bert_pkg::DIR_SYSTEM) ?
		tx_system_serial_in : line_rx_bit;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			chk_bit <= 1'b0;
			chk_valid <= 1'b0;
		end else begin
			chk_valid <= rx_slot;
			if (rx_slot) begin
				chk_bit <= rx_sample;
			end
		end
	end

	// Running counts; the latch edge clears them but keeps a bit that
	// arrives in the same cycle so no bit falls between two periods.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bit_run_r <= '0;
			err_run_r <= '0;
		end else if (load_rise) begin
			bit_run_r <= BIT_CNT_W'(chk_valid);
			err_run_r <= ERR_CNT_W'(chk_valid & chk_err);
		end else if (chk_valid) begin
			bit_run_r <= bit_run_r + 1'b1;
			if (chk_err) begin
				err_run_r <= err_run_r + 1'b1;
			end
		end
	end

	// Software-readable copies, refreshed only on the latch edge.
	// Multi-byte reads stay coherent because nothing moves between edges.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bit_latch_r <= '0;
			err_latch_r <= '0;
		end else if (load_rise) begin
			bit_latch_r <= bit_run_r;
			err_latch_r <= err_run_r;
		end
	end

endmodule

// File: sim/bert_checker_assertions.sv
// Port-level checks of the tester block: read timing, stream ownership.
// Assumes host writes to the interface control byte take effect at once.
`include "bert_params.svh"
module bert_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic bit_en,
	input wire logic tx_fbit,
	input wire logic rx_fbit,
	input wire logic tx_byte_start,
	input wire logic line_tx_bit,
	input wire logic rx_system_serial_out,
	input wire logic gen_advance,
	input wire logic gen_align,
	input wire logic chk_valid,
	input wire logic chk_bit,
	input wire logic line_rx_bit,
	input wire logic tx_system_serial_in
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [7:0] ea_r;
	// Shadow of the interface control byte, since the checker sees no state.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ea_r <= 8'h00;
		end else if (reg_wr && reg_addr == `ADDR_IF_CTRL) begin
			ea_r <= reg_wdata;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data outside its cycle");
	a_valid_cause: assert property (chk_valid |-> $past(bit_en))
		else $error("checker strobe without bit time");
	a_align_cause: assert property
		(gen_align |-> $past(bit_en && tx_byte_start))
		else $error("align pulse off a byte start");
	a_line_hold: assert property (!$past(bit_en) |-> $stable(line_tx_bit))
		else $error("line output moved between bit times");
	a_sys_hold: assert property
		(!$past(bit_en) |-> $stable(rx_system_serial_out))
		else $error("system output moved between bit times");
	a_tx_fbit: assert property
		(bit_en && tx_fbit && !ea_r[3] |-> !gen_advance)
		else $error("framed transmit F-bit taken by tester");
	a_rx_fbit: assert property (bit_en && rx_fbit && !ea_r[6] |=> !chk_valid)
		else $error("framed receive F-bit sent to checker");
	a_off_quiet: assert property (!ea_r[0] |-> !gen_advance)
		else $error("tester active while disabled");
	a_rx_owned: assert property (bit_en && ea_r[0] && !rx_fbit |=> chk_valid)
		else $error("enabled receive bit not checked");
	a_chk_feed: assert property
		(chk_valid |-> chk_bit ==
			$past(ea_r[1] ? tx_system_serial_in : line_rx_bit))
		else $error("checker bit not taken from the chosen input");
endmodule
bind bert_counters_error_insertion bert_checker u_chk (.clk, .rst_n,
	.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .bit_en, .tx_fbit,
	.rx_fbit, .tx_byte_start, .line_tx_bit, .rx_system_serial_out,
	.gen_advance, .gen_align, .chk_valid, .chk_bit, .line_rx_bit,
	.tx_system_serial_in);

// File: sim/bert_framer_model.sv
// Framer stream model: bit-time strobe, frame positions, both loopbacks.
// Assumes the tester's line output is one clock behind the slot it serves.
module bert_framer_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic clr,
	input wire logic line_tx_bit,
	input wire logic rx_system_serial_out,
	input wire logic gen_advance,
	output logic bit_en,
	output logic tx_fbit,
	output logic rx_fbit,
	output logic tx_byte_start,
	output logic framer_bit,
	output logic line_rx_bit,
	output logic tx_system_serial_in,
	output logic gen_bit,
	output logic [15:0] slots,
	output logic [15:0] errs
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] div_r;
	logic [7:0] bc_r;
	logic pend_r;
	logic exp_r;
	// One bit time in four clocks, with a running bit position.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			div_r <= 2'h0;
			bc_r <= 8'h00;
		end else begin
			div_r <= div_r + 2'h1;
			bc_r <= bc_r + {7'h00, bit_en};
		end
	end
	// Receive F-bit sits apart from the transmit one to separate the checks.
	assign bit_en = (div_r == 2'h3);
	assign tx_fbit = (bc_r[3:0] == 4'h0);
	assign rx_fbit = (bc_r[3:0] == 4'h5);
	assign tx_byte_start = (bc_r[2:0] == 3'h2);
	assign framer_bit = bc_r[1];
	assign gen_bit = bc_r[0];
	assign line_rx_bit = line_tx_bit;
	assign tx_system_serial_in = rx_system_serial_out;
	// A tester slot whose line bit differs from the generator is an insertion.
	always_ff @(posedge clk) begin
		exp_r <= gen_bit;
		if (!rst_n || clr) begin
			pend_r <= 1'b0;
			slots <= 16'h0000;
			errs <= 16'h0000;
		end else begin
			pend_r <= bit_en && gen_advance;
			slots <= slots + {15'h0000, pend_r};
			errs <= errs + {15'h0000, pend_r && (line_tx_bit != exp_r)};
		end
	end
endmodule

// File: sim/bert_counters_error_insertion_tb_top.sv
// Self-checking bench: register map, counters, quota and error insertion.
// Assumes the framer model for the stream and the bound port checker.
`include "bert_params.svh"
module bert_counters_error_insertion_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst_n, reg_wr, reg_rd, bit_en, tx_fbit, rx_fbit, tx_byte_start;
	logic framer_bit, line_rx_bit, tx_system_serial_in, line_tx_bit, clr;
	logic rx_system_serial_out, gen_bit, gen_advance, gen_align;
	logic chk_bit, chk_valid;
	logic chk_err = 1'b0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [15:0] slots, errs, nv, ne;
	int mismatches = 0;
	int samples_checked = 0;
	bert_counters_error_insertion dut (.clk, .rst_n, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .bit_en, .tx_fbit, .rx_fbit,
		.tx_byte_start, .framer_tx_bit(framer_bit), .framer_rx_bit(framer_bit),
		.line_rx_bit, .tx_system_serial_in, .line_tx_bit, .rx_system_serial_out,
		.gen_bit, .gen_advance, .gen_align, .chk_bit, .chk_valid, .chk_err);
	bert_framer_model fm (.clk, .rst_n, .clr, .line_tx_bit, .rx_system_serial_out,
		.gen_advance, .bit_en, .tx_fbit, .rx_fbit, .tx_byte_start, .framer_bit,
		.line_rx_bit, .tx_system_serial_in, .gen_bit, .slots, .errs);
	// Free-running clock at 250 MHz.
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Bench count of checked bits and of the errors the bench reports,
	// cleared with the model's counters; every other checked bit is bad.
	always @(posedge clk) begin
		nv <= clr ? 16'h0000 : nv + {15'h0000, chk_valid === 1'b1};
		ne <= clr ? 16'h0000 : ne + {15'h0000,
			(chk_valid === 1'b1) && (chk_err === 1'b1)};
		if (chk_valid === 1'b1) begin
			chk_err <= ~chk_err;
		end
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task results;
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe.
	task rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task wrrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
		logic [7:0] v;
		wr(a, d);
		rd(a, v);
		chk(v, e);
		wr(a, 8'h00);
	endtask
	task pulse_clr;
		@(posedge clk);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
	endtask
	// Register defaults, an unmapped place, unused bits and read-only bytes.
	task t_regs;
		logic [7:0] v;
		for (int a = 8'hE0; a <= 8'hF0; a++) begin
			rd(8'(a), v);
			chk(v, 8'h00);
		end
		wrrd(`ADDR_IF_CTRL, 8'hFF, 8'h5B);
		wrrd(`ADDR_RATE_CTRL, 8'hFF, 8'h9F);
		wrrd(`ADDR_QUOTA_HI, 8'hFF, 8'h03);
		wrrd(`ADDR_ERR_CNT0, 8'hFF, 8'h00);
	endtask
	// One acquisition period: counts latch to the bench's count of bits.
	task t_counts(input logic [7:0] ea);
		logic [31:0] b, e;
		logic [7:0] v;
		e = 32'h00000000;
		wr(`ADDR_IF_CTRL, 8'h00);
		wr(`ADDR_COUNTER_CTRL, 8'h00);
		wr(`ADDR_COUNTER_CTRL, 8'h02);
		pulse_clr();
		wr(`ADDR_IF_CTRL, ea);
		repeat (200) @(posedge clk);
		wr(`ADDR_IF_CTRL, 8'h00);
		repeat (4) @(posedge clk);
		wr(`ADDR_COUNTER_CTRL, 8'h00);
		wr(`ADDR_COUNTER_CTRL, 8'h02);
		for (int i = 0; i < 4; i++) begin
			rd(8'(`ADDR_BIT_CNT0 + i), v);
			b[8*i +: 8] = v;
		end
		for (int i = 0; i < 3; i++) begin
			rd(8'(`ADDR_ERR_CNT0 + i), v);
			e[8*i +: 8] = v;
		end
		chk(b, {16'h0000, nv});
		chk(e, {16'h0000, ne});
	endtask
	// Counted insertion, refused retransfer, then a ten-bit quota.
	task t_quota;
		logic [7:0] v;
		wr(`ADDR_QUOTA_LO, 8'h03);
		wr(`ADDR_RATE_CTRL, 8'h01);
		wr(`ADDR_RATE_CTRL, 8'h81);
		repeat (2) @(posedge clk);
		rd(`ADDR_LEFT_LO, v);
		chk(v, 8'h03);
		pulse_clr();
		wr(`ADDR_IF_CTRL, 8'h09);
		repeat (800) @(posedge clk);
		wr(`ADDR_IF_CTRL, 8'h00);
		rd(`ADDR_LEFT_LO, v);
		chk(v, 8'h00);
		chk(errs, 16'h0003);
		wr(`ADDR_QUOTA_LO, 8'h05);
		wr(`ADDR_QUOTA_HI, 8'h02);
		wr(`ADDR_RATE_CTRL, 8'h81);
		repeat (2) @(posedge clk);
		rd(`ADDR_LEFT_LO, v);
		chk(v, 8'h00);
		wr(`ADDR_RATE_CTRL, 8'h01);
		wr(`ADDR_RATE_CTRL, 8'h81);
		repeat (2) @(posedge clk);
		rd(`ADDR_LEFT_LO, v);
		chk(v, 8'h05);
		rd(`ADDR_LEFT_HI, v);
		chk(v, 8'h02);
	endtask
	// Constant insertion at rate codes 0, 1 and 2, past a quota of one.
	task t_constant;
		wr(`ADDR_QUOTA_HI, 8'h00);
		wr(`ADDR_QUOTA_LO, 8'h01);
		for (int r = 0; r < 3; r++) begin
			wr(`ADDR_IF_CTRL, 8'h00);
			wr(`ADDR_RATE_CTRL, 8'(8'h10 + r));
			wr(`ADDR_RATE_CTRL, 8'(8'h90 + r));
			pulse_clr();
			wr(`ADDR_IF_CTRL, 8'h09);
			repeat (600) @(posedge clk);
			wr(`ADDR_IF_CTRL, 8'h00);
			repeat (4) @(posedge clk);
			chk(errs, (r == 0) ? 16'h0000 : slots >> (r + 3));
		end
	endtask
	// A rising align bit must lead to an align pulse at a byte start.
	task t_align;
		logic seen;
		seen = 1'b0;
		wr(`ADDR_IF_CTRL, 8'h01);
		wr(`ADDR_IF_CTRL, 8'h11);
		for (int i = 0; i < 100 && !seen; i++) begin
			@(posedge clk);
			#1 seen = (gen_align === 1'b1);
		end
		chk(seen, 1'b1);
	endtask
	// Watchdog cut well past the expected run of about 3300 clocks.
	initial begin
		#200000;
		mismatches++;
		results();
	end
	// Main sequence.
	initial begin
		{rst_n, reg_wr, reg_rd, clr} = 4'h0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		repeat (5) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_counts(8'h01);
		t_counts(8'h43);
		t_quota();
		t_constant();
		t_align();
		results();
	end
endmodule
